/* File: rtl/ldp_decoder.v */
// Single-wire dimming pin decoder: brightness level and LED drive enable.
// Assumes the pin is driven by a host; clock 125 MHz, async active-low reset.
`include "ldp_regs.vh"
`default_nettype none
module ldp_decoder #(
  parameter integer SHUTDOWN_CYC = (`LDP_SHUTDOWN_NS / `LDP_CLK_PERIOD_NS),
  parameter integer START_UP_CYC = ((`LDP_START_UP_NS + `LDP_CLK_PERIOD_NS - 1) / `LDP_CLK_PERIOD_NS)
) (
  // Clock and reset
  input  wire       ref_clk_in,
  input  wire       resetn_in,
  // Control pin
  input  wire       dimming_control_pin_in,
  // Unit side
  output reg  [3:0] level_out,
  output reg        led_enable_out
);

// ------------------------------------------------------------
// Timing counts
// ------------------------------------------------------------
// Low windows are accepted inclusively at the printed limits.
localparam integer UP_MIN_I  = (`LDP_MODE_UP_MIN_NS + `LDP_CLK_PERIOD_NS - 1) / `LDP_CLK_PERIOD_NS;
localparam integer UP_MAX_I  = `LDP_MODE_UP_MAX_NS / `LDP_CLK_PERIOD_NS;
localparam integer DN_MIN_I  = (`LDP_MODE_DN_MIN_NS + `LDP_CLK_PERIOD_NS - 1) / `LDP_CLK_PERIOD_NS;
localparam integer DN_MAX_I  = `LDP_MODE_DN_MAX_NS / `LDP_CLK_PERIOD_NS;
localparam integer HI_MAX_I  = `LDP_PROG_HIGH_MAX_NS / `LDP_CLK_PERIOD_NS;
localparam integer PS_OPEN_I = (`LDP_PRESET_OPEN_NS + `LDP_CLK_PERIOD_NS - 1) / `LDP_CLK_PERIOD_NS;
localparam integer PS_SHUT_I = `LDP_PRESET_CLOSE_NS / `LDP_CLK_PERIOD_NS;
localparam integer ONE_I     = 1;

// Counts are cut to the counter width on purpose
localparam [`LDP_CNT_W-1:0] UP_MIN  = UP_MIN_I[`LDP_CNT_W-1:0];
localparam [`LDP_CNT_W-1:0] UP_MAX  = UP_MAX_I[`LDP_CNT_W-1:0];
localparam [`LDP_CNT_W-1:0] DN_MIN  = DN_MIN_I[`LDP_CNT_W-1:0];
localparam [`LDP_CNT_W-1:0] DN_MAX  = DN_MAX_I[`LDP_CNT_W-1:0];
localparam [`LDP_CNT_W-1:0] HI_MAX  = HI_MAX_I[`LDP_CNT_W-1:0];
localparam [`LDP_CNT_W-1:0] PS_OPEN = PS_OPEN_I[`LDP_CNT_W-1:0];
localparam [`LDP_CNT_W-1:0] PS_SHUT = PS_SHUT_I[`LDP_CNT_W-1:0];
localparam [`LDP_CNT_W-1:0] SD_CYC  = SHUTDOWN_CYC[`LDP_CNT_W-1:0];
localparam [`LDP_CNT_W-1:0] SU_CYC  = START_UP_CYC[`LDP_CNT_W-1:0];
localparam [`LDP_CNT_W-1:0] CNT_ONE = ONE_I[`LDP_CNT_W-1:0];

// ------------------------------------------------------------
// States
// ------------------------------------------------------------
localparam [3:0] ST_OFF    = 4'h1;
localparam [3:0] ST_WAIT   = 4'h2;
localparam [3:0] ST_PRESET = 4'h4;
localparam [3:0] ST_RUN    = 4'h8;

reg  [3:0]            state_reg;
reg  [1:0]            sync_reg;
reg                   pin_reg;
reg  [`LDP_CNT_W-1:0] cnt_reg;
reg                   mode_up_reg;
reg                   pend_reg;
reg                   burst_reg;
reg                   armed_reg;

wire pin  = sync_reg[1];
wire fall = pin_reg & ~pin;
wire rise = ~pin_reg & pin;

// Wrapping step in either direction
function [3:0] step;
  input [3:0] lvl;
  input       up;
  begin
    step = up ? lvl + 4'h1 : lvl - 4'h1;
  end
endfunction

// ------------------------------------------------------------
// Duration decode
// ------------------------------------------------------------
// Inclusive range test on the running duration count
function in_range;
  input [`LDP_CNT_W-1:0] val;
  input [`LDP_CNT_W-1:0] lo;
  input [`LDP_CNT_W-1:0] hi;
  begin
    in_range = (val >= lo) && (val <= hi);
  end
endfunction

// The count equals the level's length in cycles at the next edge
wire in_up_win = in_range(cnt_reg, UP_MIN, UP_MAX);
wire in_dn_win = in_range(cnt_reg, DN_MIN, DN_MAX);
// Falling edges outside this window disarm preset for the whole start-up
wire in_ps_win = in_range(cnt_reg, PS_OPEN, PS_SHUT);
wire hi_ok     = (cnt_reg <= HI_MAX);
wire su_done   = pin && (cnt_reg >= SU_CYC);
// Shutdown outranks every state so a stuck low always clears
wire long_low  = !pin && (cnt_reg >= SD_CYC);

// ------------------------------------------------------------
// Pin synchroniser
// ------------------------------------------------------------
always @(posedge ref_clk_in or negedge resetn_in) begin
  if (!resetn_in) begin
    sync_reg <= 2'h0;
  end else begin
    sync_reg <= {sync_reg[0], dimming_control_pin_in};
  end
end

// Edge register holds the previous synchronised level
always @(posedge ref_clk_in or negedge resetn_in) begin
  if (!resetn_in) begin
    pin_reg <= 1'b0;
  end else begin
    pin_reg <= pin;
  end
end

// ------------------------------------------------------------
// Decoder
// ------------------------------------------------------------
// Counter restarts at each pin change and saturates, so long levels never wrap.
always @(posedge ref_clk_in or negedge resetn_in) begin
  if (!resetn_in) begin
    state_reg      <= ST_OFF;
    cnt_reg        <= {`LDP_CNT_W{1'b0}};
    mode_up_reg    <= 1'b0;
    pend_reg       <= 1'b0;
    burst_reg      <= 1'b0;
    armed_reg      <= 1'b0;
    level_out      <= `LDP_LEVEL_MAX;
    led_enable_out <= 1'b0;
  end else begin
    if (rise || fall)
      cnt_reg <= CNT_ONE;
    else if (cnt_reg != {`LDP_CNT_W{1'b1}})
      cnt_reg <= cnt_reg + CNT_ONE;
    if (long_low && state_reg != ST_OFF) begin
      state_reg      <= ST_OFF;
      level_out      <= `LDP_LEVEL_MAX;
      mode_up_reg    <= 1'b0;
      led_enable_out <= 1'b0;
      pend_reg       <= 1'b0;
      burst_reg      <= 1'b0;
    end else begin
      case (state_reg)
        ST_OFF: begin
          if (rise) begin
            state_reg   <= ST_WAIT;
            level_out   <= `LDP_LEVEL_MAX;
            mode_up_reg <= 1'b0;
            armed_reg   <= 1'b0;
          end
        end
        ST_WAIT: begin
          if (fall && !armed_reg && in_ps_win) begin
            state_reg <= ST_PRESET;
            level_out <= step(level_out, 1'b0);
          end else if (fall) begin
            armed_reg <= 1'b1;
          end else if (su_done) begin
            state_reg      <= ST_RUN;
            led_enable_out <= 1'b1;
          end
        end
        ST_PRESET: begin
          if (fall)
            level_out <= step(level_out, 1'b0);
          else if (su_done) begin
            state_reg      <= ST_RUN;
            led_enable_out <= 1'b1;
          end
        end
        ST_RUN: begin
          if (rise) begin
            pend_reg <= 1'b0;
            if (in_up_win) begin
              mode_up_reg <= 1'b1;
              pend_reg    <= 1'b1;
            end else if (in_dn_win) begin
              mode_up_reg <= 1'b0;
              pend_reg    <= 1'b1;
            end
          end
          if (fall) begin
            if (pend_reg && hi_ok) begin
              level_out <= step(level_out, mode_up_reg);
              burst_reg <= 1'b1;
            end else if (burst_reg && hi_ok) begin
              level_out <= step(level_out, mode_up_reg);
            end else begin
              burst_reg <= 1'b1;
            end
            pend_reg <= 1'b0;
          end
          // At a rise the count is the low length, not a high time
          if (pin && !rise && !hi_ok) begin
            burst_reg <= 1'b0;
            pend_reg  <= 1'b0;
          end
        end
        default: state_reg <= ST_OFF;
      endcase
    end
  end
end

endmodule
`default_nettype wire

/* File: rtl/ldp_regs.vh */
// Timing and value constants for the dimming pin decoder.
// Assumes a 125 MHz clock; times are in nanoseconds.
`ifndef LDP_REGS_VH
`define LDP_REGS_VH
`define LDP_CLK_PERIOD_NS     8
`define LDP_MODE_UP_MIN_NS    100000
`define LDP_MODE_UP_MAX_NS    160000
`define LDP_MODE_DN_MIN_NS    420000
`define LDP_MODE_DN_MAX_NS    500000
`define LDP_SHUTDOWN_NS       1260000
`define LDP_PROG_HIGH_MAX_NS  32000
`define LDP_PRESET_OPEN_NS    35000
`define LDP_PRESET_CLOSE_NS   50000
`define LDP_START_UP_NS       140000
`define LDP_LEVEL_MAX         4'h0f
`define LDP_LEVEL_MIN         4'h0
`define LDP_CNT_W             18
`endif

/* File: verification/ldp_decoder_properties.sv */
// Port assertions for ldp_decoder; attached by the bind below.
`default_nettype none
module ldp_decoder_properties #(parameter integer SHUTDOWN_CYC = 157500, parameter integer START_UP_CYC = 17500) (
  input wire logic       ref_clk_in,
  input wire logic       resetn_in,
  input wire logic       dimming_control_pin_in,
  input wire logic [3:0] level_out,
  input wire logic       led_enable_out
);
  timeunit 1ns / 1ps;
  wire         pin = dimming_control_pin_in;
  logic [17:0] hi, lo;
  always_ff @(posedge ref_clk_in or negedge resetn_in)
    if (!resetn_in) {hi, lo} <= 36'h0;
    else {hi, lo} <= pin ? {hi + 18'h1, 18'h0} : {18'h0, lo + 18'h1};
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);
  pin_low_a: assert property ($changed(level_out) |-> !pin) else $error("step, pin high");
  sync_delay_a: assert property ($changed(level_out) |-> !$past(pin, 3)) else $error("step too soon");
  step_one_a: assert property ($changed(level_out) && lo < 16 |->
    level_out - $past(level_out) inside {4'h1, 4'hf}) else $error("bad step");
  preset_down_a: assert property ($changed(level_out) && !led_enable_out && lo < 16 |->
    level_out == $past(level_out) - 4'h1) else $error("preset went up");
  gap_hold_a: assert property ($changed(level_out) |-> lo < 16 || lo >= SHUTDOWN_CYC) else $error("gap step");
  start_wait_a: assert property ($rose(led_enable_out) |-> hi >= START_UP_CYC) else $error("drive early");
  drive_hold_a: assert property (led_enable_out && lo < SHUTDOWN_CYC |=> led_enable_out) else $error("drive lost");
  shutdown_clr_a: assert property (lo == SHUTDOWN_CYC + 8 |->
    level_out == 4'hf && !led_enable_out) else $error("not cleared");
endmodule
bind ldp_decoder ldp_decoder_properties #(.SHUTDOWN_CYC(SHUTDOWN_CYC), .START_UP_CYC(START_UP_CYC)) props (.*);
`default_nettype wire

/* File: verification/ldp_host.sv */
// Host pin model; needs a free-running clock.
`default_nettype none
module ldp_host (
  input  wire logic clk_in,
  output var logic  pin_out = 1'b0
);
  timeunit 1ns / 1ps;
  task automatic seg(input logic v, input int cyc);
    @(negedge clk_in) pin_out <= v;
    repeat (cyc) @(posedge clk_in);
  endtask
  task automatic burst(input int lo_cyc);
    seg(1'b0, lo_cyc);
    seg(1'b1, 1250);
    seg(1'b0, 1250);
  endtask
endmodule
`default_nettype wire

/* File: verification/ldp_decoder_bench.sv */
// Decoder bench; assumes ldp_host and the bound checker.
`default_nettype none
module ldp_decoder_bench;
  timeunit 1ns / 1ps;
  // Start-up must outlast the preset window or preset never opens
  localparam int SU = 7000;
  logic       clk = 1'b0, rst_n = 1'b0;
  wire        pin, en;
  wire  [3:0] level;
  int         failures = 0, n_compared = 0;
  always #4 clk = ~clk;
  ldp_host host (.clk_in(clk), .pin_out(pin));
  // Shutdown just above the widest mode window keeps the run short
  ldp_decoder #(.SHUTDOWN_CYC(62600), .START_UP_CYC(SU)) dut (.ref_clk_in(clk), .resetn_in(rst_n),
    .dimming_control_pin_in(pin), .level_out(level), .led_enable_out(en));
  task automatic chk(input logic [3:0] lv, input logic e, input string s);
    @(negedge clk);
    n_compared++;
    if (level !== lv || en !== e) begin
      failures++;
      $display("[ERR] %0t mismatch level %h en %b", $time, level, en);
    end
    if (s != "") $display("%s end", s);
  endtask
  task automatic t_preset;
    chk(4'hf, 1'b0, "");
    host.seg(1'b1, 5000);
    host.burst(1250);
    host.seg(1'b1, SU - 20);
    chk(4'hd, 1'b0, "");
    host.seg(1'b1, 100);
    chk(4'hd, 1'b1, "preset");
  endtask
  task automatic t_up;
    host.burst(12500);
    host.seg(1'b1, 4500);
    chk(4'he, 1'b1, "up");
  endtask
  task automatic t_down;
    host.burst(52500);
    host.seg(1'b1, 4500);
    chk(4'hd, 1'b1, "down");
  endtask
  task automatic t_burst;
    host.seg(1'b0, 1250);
    host.seg(1'b1, 1250);
    host.burst(1250);
    host.seg(1'b1, 4500);
    chk(4'h0, 1'b1, "burst");
  endtask
  task automatic t_shutdown;
    host.seg(1'b0, 62700);
    chk(4'hf, 1'b0, "");
    host.seg(1'b1, 1000);
    host.seg(1'b0, 1250);
    host.seg(1'b1, SU + 100);
    chk(4'hf, 1'b1, "");
    host.seg(1'b0, 1250);
    host.seg(1'b1, 1250);
    host.seg(1'b0, 1250);
    host.seg(1'b1, 4500);
    chk(4'he, 1'b1, "shutdown");
  endtask
  task automatic end_of_test;
    $display("%0d compared, %0d failures", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    @(negedge clk) rst_n <= 1'b1;
    t_preset();
    t_up();
    t_burst();
    t_shutdown();
    t_down();
    end_of_test();
  end
endmodule
`default_nettype wire
